// file: test/pti_host.sv
// Host model sending serial command frames
`timescale 1ns/1ps
`default_nettype none
module pti_host (
	input wire logic ref_clk,
	output var logic chip_select_n = 1'b1,
	output var logic serial_clock = 1'b0,
	output var logic serial_data_in = 1'b0
);
	// Frame select, changed just after a clock edge
	task automatic sel(input logic v);
		@(posedge ref_clk) chip_select_n <= v;
	endtask
	// Serial clocks from..to, command MSB first, then data low; clock still after
	task automatic clk_bits(input logic [7:0] cmd, input int from, input int to);
		for (int k = from; k <= to; k++) begin
			@(posedge ref_clk) serial_data_in <= (k <= 8) ? cmd[8 - k] : 1'b0;
			repeat (4) @(posedge ref_clk);
			serial_clock <= 1'b1;
			repeat (4) @(posedge ref_clk);
			serial_clock <= 1'b0;
		end
	endtask
	// Bench reads the interrupt only at settled points, including mid-frame after the 12th clock
endmodule // pti_host
`default_nettype wire

// file: test/pti_top_assertions.sv
// Checker on the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module pti_top_assertions (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic plate_touched,
	input wire logic pen_touch_irq_n
);
	logic [2:0] pins_d_r;
	logic [2:0] quiet_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Cycles since any pin that steers the output last moved
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pins_d_r <= 3'h4;
			quiet_r <= 3'h0;
		end else begin
			pins_d_r <= {chip_select_n, serial_clock, plate_touched};
			if ({chip_select_n, serial_clock, plate_touched} != pins_d_r) begin
				quiet_r <= 3'h0;
			end else if (quiet_r != 3'h7) begin
				quiet_r <= quiet_r + 3'h1;
			end
		end
	end
	// Pin held high through reset
	reset_level_a: assert property (disable iff (1'b0) reset |=> pen_touch_irq_n)
		else $error("pin low in reset");
	// Pin high right after reset release
	release_high_a: assert property ($fell(reset) |-> pen_touch_irq_n)
		else $error("pin low after reset");
	// Pin moves only after some pin activity
	output_quiet_a: assert property (quiet_r >= 3'h5 |-> $stable(pen_touch_irq_n))
		else $error("pin moved without cause");
	// Idle and untouched gives a high pin
	idle_high_a: assert property ((chip_select_n && !plate_touched)[*6] |-> pen_touch_irq_n)
		else $error("pin low while idle");
	// Idle pin moves only with touch
	idle_steady_a: assert property ((chip_select_n && $stable(plate_touched))[*6]
		|=> $stable(pen_touch_irq_n))
		else $error("pin moved while idle");
	// No serial clocking and steady touch keeps the pin
	frame_steady_a: assert property ((!chip_select_n && !serial_clock && $stable(plate_touched))[*6]
		|=> $stable(pen_touch_irq_n))
		else $error("pin moved in frame");
	// Main scenarios
	cover property (!chip_select_n && !pen_touch_irq_n);
	cover property (chip_select_n && plate_touched && pen_touch_irq_n);
	cover property (chip_select_n && plate_touched && !pen_touch_irq_n);
endmodule // pti_top_assertions
bind pti_top pti_top_assertions pti_top_assertions_inst (.ref_clk, .reset, .chip_select_n,
	.serial_clock, .serial_data_in, .plate_touched, .pen_touch_irq_n);
`default_nettype wire

// file: test/test_pti_top.sv
// Self-checking bench for the interrupt output
`timescale 1ns/1ps
`default_nettype none
module test_pti_top;
	logic ref_clk, reset, plate_touched, chip_select_n, serial_clock, serial_data_in;
	logic pen_touch_irq_n;
	int bad_count = 0;
	int checks_done = 0;
	logic old_pd0 = 1'b0;
	logic old_axis = 1'b0;
	logic [7:0] cmds [6] = '{8'hd1, 8'h91, 8'ha1, 8'hd0, 8'ha3, 8'hd3};
	pti_top pti_top_inst (.ref_clk, .reset, .chip_select_n, .serial_clock, .serial_data_in,
		.plate_touched, .pen_touch_irq_n);
	pti_host pti_host_inst (.ref_clk, .chip_select_n, .serial_clock, .serial_data_in);
	// Compare and count
	task automatic check(input string what, input logic seen, input logic exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One frame at a touch level, pin checked in each phase
	task automatic frame_check(input logic [7:0] cmd, input logic t);
		logic axis;
		axis = (cmd[5:4] == 2'b01);
		@(posedge ref_clk) plate_touched <= t;
		repeat (8) @(negedge ref_clk);
		pti_host_inst.sel(1'b0);
		repeat (6) @(negedge ref_clk);
		check("head", pen_touch_irq_n, old_pd0 ? ~old_axis : ~t);
		pti_host_inst.clk_bits(cmd, 1, 12);
		repeat (6) @(negedge ref_clk);
		check("conv", pen_touch_irq_n, ~axis);
		pti_host_inst.clk_bits(cmd, 13, 24);
		repeat (6) @(negedge ref_clk);
		check("tail", pen_touch_irq_n, cmd[0] ? ~axis : ~t);
		pti_host_inst.sel(1'b1);
		repeat (6) @(negedge ref_clk);
		check("idle", pen_touch_irq_n, ~(t & ~(cmd[1] & cmd[0])));
		old_pd0 = cmd[0];
		old_axis = axis;
	endtask
	// Reset in mid-run: pin high and remembered bits cleared
	task automatic reset_midrun();
		@(posedge ref_clk) reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(negedge ref_clk);
		check("reset", pen_touch_irq_n, 1'b1);
		old_pd0 = 1'b0;
		old_axis = 1'b0;
	endtask
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Reset, then every command untouched and touched
	initial begin
		reset = 1'b1;
		plate_touched = 1'b0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 12; i++) begin
			if (i == 6) begin
				reset_midrun();
			end
			frame_check(cmds[i % 6], i >= 6);
		end
		final_report();
	end
	// Watchdog
	initial begin
		#500000;
		bad_count++;
		final_report();
	end
endmodule // test_pti_top
`default_nettype wire

// file: verilog/pti_defines.svh
// Constants for the pen touch interrupt output logic
`ifndef PTI_DEFINES_SVH
`define PTI_DEFINES_SVH
`define PTI_CNT_W 5
`define PTI_EDGE_TRACK 5'd5
`define PTI_EDGE_PD1 5'd7
`define PTI_EDGE_PD0 5'd8
`define PTI_EDGE_CONV_END 5'd20
`define PTI_CNT_MAX 5'd31
`define PTI_CMD_W 8
`define PTI_BIT_PD1 1
`define PTI_BIT_PD0 0
`define PTI_BIT_A2 6
`define PTI_BIT_A0 4
`define PTI_CMD_RESET 8'h00
`define PTI_PIN_IDLE 4'h1
`endif

// file: verilog/pti_pkg.sv
// Types for the pen touch interrupt output logic
package pti_pkg;
	typedef enum logic [1:0] {
		PTI_PH_IDLE,
		PTI_PH_HEAD,
		PTI_PH_CONV,
		PTI_PH_TAIL
	} pti_phase_type;
	typedef logic [2:0] pti_chan_type;
endpackage

// file: verilog/pti_sync.sv
// Two-stage synchroniser for one input from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pti_sync (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic async_in,
	input wire logic reset_val,
	output logic sync_out
);
	logic meta_r;
	logic hold_r;

	// First stage feeds only the second
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_r <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			meta_r <= async_in ^ reset_val;
			hold_r <= meta_r;
		end
	end

	assign sync_out = hold_r ^ reset_val;
endmodule // pti_sync
`default_nettype wire

// file: verilog/pti_top.sv
// Pen touch interrupt output driven from serial frame phase and power bits
// Contract
// - Before 5th clock, old ADC power bit 0: output follows touch.
// - Before 5th clock, old power 1 and axis channel: output low.
// - Before 5th clock, old power 1 and other channel: output high.
// - 5th to 20th falling edge, axis channel selected: output forced low.
// - 5th to 20th falling edge, other channel selected: output forced high.
// - After 20th edge, new ADC power bit 0: output follows touch.
// - After 20th edge, power 1 and axis channel: output low.
// - After 20th edge, power 1 and other channel: output high.
// - ADC power bit updates at the 8th rising serial clock edge.
// - Chip-select high: touch drives low unless both power bits were 1.
`timescale 1ns/1ps
`default_nettype none
`include "pti_defines.svh"
module pti_top (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic plate_touched,
	output logic pen_touch_irq_n
);
	import pti_pkg::*;

	// Frame structure seen by this block:
	// head from select fall to the 5th falling serial clock,
	// conversion from the 5th to the 20th falling serial clock,
	// tail from the 20th falling serial clock to select rise,
	// idle while select is high.
	// Every pin is resynchronised, so all decisions lag the pins
	// by a few reference clocks; the host masks frames anyway.

	localparam logic [3:0] PIN_IDLE = `PTI_PIN_IDLE;

	logic [3:0] pin_raw;
	logic [3:0] pin_sync;
	logic cs_n_s;
	logic sclk_s;
	logic din_s;
	logic touch_s;
	logic sclk_d_r;
	logic sclk_rise;
	logic sclk_fall;
	logic started_r;
	logic [`PTI_CNT_W-1:0] rise_cnt_r;
	logic [`PTI_CNT_W-1:0] fall_cnt_r;
	logic [`PTI_CMD_W-1:0] cmd_r;
	logic adc_power_bit;
	logic ref_power_bit;
	logic axis_cur_r;
	logic axis_last_r;
	logic cs_n_d_r;
	logic frame_end;
	logic cur_axis;
	logic head_level;
	logic tail_level;
	logic idle_level;
	logic irq_nxt;
	logic pen_touch_irq_r;
	pti_phase_type phase;

	// Pins gathered so that one synchroniser per bit is generated
	assign pin_raw = {plate_touched, serial_data_in, serial_clock, chip_select_n};

	// Two flip-flops per pin; chip select idles high, the rest low
	for (genvar g = 0; g < 4; g++) begin : g_pin_sync
		pti_sync pti_sync_inst (
			.ref_clk(ref_clk),
			.reset(reset),
			.async_in(pin_raw[g]),
			.reset_val(PIN_IDLE[g]),
			.sync_out(pin_sync[g])
		);
	end

	// Named copies of the synchronised pins
	assign cs_n_s = pin_sync[0];
	assign sclk_s = pin_sync[1];
	assign din_s = pin_sync[2];
	assign touch_s = pin_sync[3];

	// Serial clock edge detection on the synchronised copy
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign sclk_fall = ~sclk_s & sclk_d_r;

	// Count edges from the start bit; counting begins at first high data bit
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			started_r <= 1'b0;
			rise_cnt_r <= '0;
			fall_cnt_r <= '0;
			cmd_r <= `PTI_CMD_RESET;
		end else if (cs_n_s) begin
			started_r <= 1'b0;
			rise_cnt_r <= '0;
			fall_cnt_r <= '0;
		end else begin
			if (sclk_rise && (started_r || din_s)) begin
				started_r <= 1'b1;
				if (rise_cnt_r != `PTI_CNT_MAX) begin
					rise_cnt_r <= rise_cnt_r + 1'b1;
				end
				if (rise_cnt_r < `PTI_EDGE_PD0) begin
					cmd_r <= {cmd_r[`PTI_CMD_W-2:0], din_s};
				end
			end
			if (sclk_fall && started_r && fall_cnt_r != `PTI_CNT_MAX) begin
				fall_cnt_r <= fall_cnt_r + 1'b1;
			end
		end
	end

	// Channel class of the command shifting in.
	// By the 5th rise the low four bits hold start, A2, A1, A0,
	// so A1..A0 = 01 marks the X (101) and Y (001) axes.
	assign cur_axis = (cmd_r[1:0] == 2'b01);

	// Power bits: reference at the 7th rise, ADC at the 8th rise.
	// The old ADC bit stays in force for the head of the frame.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			adc_power_bit <= 1'b0;
			ref_power_bit <= 1'b0;
		end else if (!cs_n_s && sclk_rise && started_r) begin
			if (rise_cnt_r == `PTI_EDGE_PD1 - 5'd1) begin
				ref_power_bit <= din_s;
			end
			if (rise_cnt_r == `PTI_EDGE_PD0 - 5'd1) begin
				adc_power_bit <= din_s;
			end
		end
	end

	// Class of this frame, taken at the 5th rise once A0 is in
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			axis_cur_r <= 1'b0;
		end else if (!cs_n_s && sclk_rise && started_r
			&& rise_cnt_r == `PTI_EDGE_TRACK - 5'd1) begin
			axis_cur_r <= cur_axis;
		end
	end

	// Frame end is the synchronised select going high
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cs_n_d_r <= 1'b1;
		end else begin
			cs_n_d_r <= cs_n_s;
		end
	end
	assign frame_end = cs_n_s & ~cs_n_d_r;

	// Class of the previous frame, held for the next head.
	// Kept apart from the current class so that the head does not
	// switch early when the 5th rise comes before the 5th fall.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			axis_last_r <= 1'b0;
		end else if (frame_end) begin
			axis_last_r <= axis_cur_r;
		end
	end

	// Frame phase from chip select and falling edge count
	always_comb begin
		if (cs_n_s) begin
			phase = PTI_PH_IDLE;
		end else if (fall_cnt_r < `PTI_EDGE_TRACK) begin
			phase = PTI_PH_HEAD;
		end else if (fall_cnt_r < `PTI_EDGE_CONV_END) begin
			phase = PTI_PH_CONV;
		end else begin
			phase = PTI_PH_TAIL;
		end
	end

	// Head level: previous ADC bit and previous class
	assign head_level = adc_power_bit ? ~axis_last_r : ~touch_s;
	// Tail level: new ADC bit and this frame's class
	assign tail_level = adc_power_bit ? ~axis_cur_r : ~touch_s;
	// Idle level: touch pulls low unless both power bits are set
	assign idle_level = (ref_power_bit & adc_power_bit) ? 1'b1 : ~touch_s;

	// Output level per phase; false lows in frames are the host's to mask
	always_comb begin
		case (phase)
			PTI_PH_IDLE: irq_nxt = idle_level;
			PTI_PH_HEAD: irq_nxt = head_level;
			PTI_PH_CONV: irq_nxt = ~axis_cur_r;
			PTI_PH_TAIL: irq_nxt = tail_level;
			default: irq_nxt = 1'b1;
		endcase
	end

	// Registered output, set high by reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pen_touch_irq_r <= 1'b1;
		end else begin
			pen_touch_irq_r <= irq_nxt;
		end
	end
	assign pen_touch_irq_n = pen_touch_irq_r;
endmodule // pti_top
`default_nettype wire
